// ---- dv/gac_host_model.sv ----
`timescale 1ns/1ps
module gac_host_model (
  input wire logic clk_i,
  output logic write_strobe_n_o,
  output logic read_strobe_n_o,
  output logic cmd_data_select_o,
  output logic [gac_pkg::GAC_DATA_W-1:0] data_o,
  output logic ext_cmd_en_o
);
  import gac_pkg::*;

  // Idle bus levels at time zero
  initial begin
    write_strobe_n_o = 1'b1;
    read_strobe_n_o = 1'b1;
    cmd_data_select_o = 1'b1;
    data_o = '0;
    ext_cmd_en_o = 1'b0;
  end

  // Extension-command enable, set before the gamma commands
  task automatic set_en(input logic lvl);
    @(posedge clk_i);
    #1;
    ext_cmd_en_o = lvl;
  endtask

  // One byte: strobe low one cycle, rising edge, hold to the sampling edge
  task automatic wr_byte(input logic dcx, input logic rdn, input gac_byte_t b);
    @(posedge clk_i);
    #1;
    write_strobe_n_o = 1'b0;
    read_strobe_n_o = rdn;
    cmd_data_select_o = dcx;
    data_o = {~data_o[GAC_DATA_W-1:GAC_BYTE_W], b}; // Upper lines toggle as don't-care
    @(posedge clk_i);
    #1;
    write_strobe_n_o = 1'b1;
    @(posedge clk_i);
    #1;
    // Released lines no longer show the last value
    data_o = ~data_o;
    cmd_data_select_o = ~dcx;
    read_strobe_n_o = 1'b1;
  endtask
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
  import gac_pkg::*;

  localparam logic [15:0] DEF = {4'h0, 3'h2, 3'h2, 3'h0, 3'h7};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b1;
  logic sw_reset_i = 1'b0;
  logic wr_n, rd_n, dcx, en;
  logic [GAC_DATA_W-1:0] data;
  logic [3:0] pos;
  logic [2:0] f0, f1, f2, f3;
  logic pend;
  logic [15:0] regs;
  int mismatches = 0;
  int n_tests = 0;

  // Clock, 8 ns period
  always #4 clk_i = ~clk_i;

  gac_host_model host (.clk_i(clk_i), .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n),
    .cmd_data_select_o(dcx), .data_o(data), .ext_cmd_en_o(en));

  gac_cmd_regs dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_data_select_i(dcx), .read_strobe_n_i(rd_n),
    .write_strobe_n_i(wr_n), .data_i(data), .ext_cmd_en_i(en), .sw_reset_i(sw_reset_i),
    .pos_amplitude_sel_1_o(pos), .neg_fine_sel_0_o(f0), .neg_fine_sel_1_o(f1), .neg_fine_sel_2_o(f2),
    .neg_fine_sel_3_o(f3), .param_pending_o(pend));

  // All settings packed as amplitude, fine 3, 2, 1, 0
  assign regs = {pos, f3, f2, f1, f0};

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask

  // Command byte, then pending flag one edge after the taking edge
  task automatic wr_cmd(input gac_byte_t c, input logic p);
    host.wr_byte(1'b0, 1'b1, c);
    settle();
    chk("pending", {15'h0000, p}, {15'h0000, pend});
  endtask

  // Parameter byte, then all settings
  task automatic wr_par(input gac_byte_t b, input logic [15:0] e);
    host.wr_byte(1'b1, 1'b1, b);
    settle();
    chk("settings", e, regs);
  endtask

  // Watchdog
  initial begin
    #200000;
    mismatches++;
    test_done();
  end

  // Sequences; no display-state input, so acceptance hangs only on the extension enable
  initial begin
    // Reset dropped after time zero so the asynchronous branch sees an edge
    #1;
    rst_n_i = 1'b0;
    repeat (16) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    chk("reset", DEF, regs);
    wr_cmd(8'hF5, 1'b0);
    wr_par(8'h0A, DEF);
    host.set_en(1'b1);
    wr_cmd(8'hF5, 1'b1);
    wr_par(8'hFA, {4'hA, DEF[11:0]});
    wr_par(8'h03, {4'hA, DEF[11:0]});
    wr_cmd(8'hF7, 1'b1);
    wr_par(8'hB5, {4'hA, 3'h2, 3'h2, 3'h3, 3'h5});
    wr_cmd(8'hF8, 1'b1);
    host.wr_byte(1'b1, 1'b0, 8'h11);
    settle();
    chk("read low", {15'h0000, 1'b1}, {15'h0000, pend});
    wr_par(8'hC6, {4'hA, 3'h4, 3'h6, 3'h3, 3'h5});
    wr_cmd(8'hF6, 1'b0);
    wr_par(8'h0F, {4'hA, 3'h4, 3'h6, 3'h3, 3'h5});
    @(posedge clk_i);
    #1;
    sw_reset_i = 1'b1;
    settle();
    sw_reset_i = 1'b0;
    chk("soft reset", DEF, regs);
    wr_cmd(8'hF8, 1'b1);
    wr_par(8'h55, {4'h0, 3'h5, 3'h5, 3'h0, 3'h7});
    wr_cmd(8'hF5, 1'b1);
    rst_n_i = 1'b0;
    #1;
    chk("hard reset", DEF, regs);
    repeat (4) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    chk("pending reset", 16'h0000, {15'h0000, pend});
    wr_cmd(8'hF7, 1'b1);
    wr_par(8'h70, {4'h0, 3'h2, 3'h2, 3'h7, 3'h0});
    test_done();
  end
endmodule

// ---- hw/gac_cmd_regs.sv ----
`timescale 1ns/1ps
// Functional notes
// RQ1: A command byte is taken with command/data select low and read strobe high on a rising write strobe.
// RQ2: Command F5h stores the low nibble of its parameter as the positive amplitude setting, upper bits ignored.
// RQ3: Command F7h stores D6-D4 as negative fine setting one and D2-D0 as setting zero.
// RQ4: Command F8h stores D6-D4 as negative fine setting three and D2-D0 as setting two.
// RQ5: The gamma commands are acted on only while the extension-command enable is high.
// RQ6: The gamma commands are accepted in every display, idle and sleep state.
// RQ7: After any reset the positive amplitude setting is zero.
// RQ8: After any reset negative fine setting one is zero and setting zero is seven.
// RQ9: After power-on and software reset negative fine settings three and two are each two.
// RQ10: The host sends a parameter byte with command/data select high and read strobe high on a rising write strobe.
// RQ11: Hardware reset also loads two into negative fine settings three and two.
module gac_cmd_regs #(
  parameter int DATA_W = gac_pkg::GAC_DATA_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_data_select_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic ext_cmd_en_i,
  input wire logic sw_reset_i,
  output logic [gac_pkg::GAC_POS_AMP_W-1:0] pos_amplitude_sel_1_o,
  output logic [gac_pkg::GAC_FINE_W-1:0] neg_fine_sel_0_o,
  output logic [gac_pkg::GAC_FINE_W-1:0] neg_fine_sel_1_o,
  output logic [gac_pkg::GAC_FINE_W-1:0] neg_fine_sel_2_o,
  output logic [gac_pkg::GAC_FINE_W-1:0] neg_fine_sel_3_o,
  output logic param_pending_o
);
  import gac_pkg::*;

  // Bus must at least carry one byte
  if (DATA_W < GAC_BYTE_W) begin : g_bad_width
    $error("DATA_W must be at least one byte");
  end

  gac_wr_if wr ();

  gac_state_e state_q, state_d;
  gac_idx_t tgt_q, tgt_d;

  // Pin capture of command and parameter bytes
  gac_wr_edge #(
    .DATA_W(DATA_W)
  ) u_edge (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .write_strobe_n_i(write_strobe_n_i),
    .read_strobe_n_i(read_strobe_n_i),
    .cmd_data_select_i(cmd_data_select_i),
    .data_i(data_i),
    .wr(wr.edge_mp)
  );

  // Gamma setting registers
  gac_reg_store u_store (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .st(wr.store_mp)
  );

  // Command decode: any command byte ends a pending parameter wait
  always_comb begin
    state_d = state_q;
    tgt_d = tgt_q;
    wr.we = 1'b0;
    wr.widx = tgt_q;
    wr.wdata = wr.wbyte;
    wr.swrst = sw_reset_i;
    // No display or sleep state gates the decoder [RQ6]
    if (wr.evt) begin
      if (!wr.is_param) begin
        state_d = GAC_ST_IDLE; // [RQ1]
        if (ext_cmd_en_i) begin // [RQ5]
          unique case (wr.wbyte)
            GAC_CMD_POS_AMP_1: begin
              state_d = GAC_ST_PARAM; // [RQ2]
              tgt_d = GAC_IDX_POS_AMP_1;
            end
            GAC_CMD_NEG_FINE_1_0: begin
              state_d = GAC_ST_PARAM; // [RQ3]
              tgt_d = GAC_IDX_NEG_FINE_1_0;
            end
            GAC_CMD_NEG_FINE_3_2: begin
              state_d = GAC_ST_PARAM; // [RQ4]
              tgt_d = GAC_IDX_NEG_FINE_3_2;
            end
            default: begin
              state_d = GAC_ST_IDLE;
            end
          endcase
        end
      end else if (state_q == GAC_ST_PARAM) begin
        // First parameter only; later ones are ignored
        wr.we = 1'b1; // [RQ10]
        state_d = GAC_ST_IDLE;
      end
    end
    if (sw_reset_i) begin
      state_d = GAC_ST_IDLE;
      wr.we = 1'b0;
    end
  end

  // Decoder state registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= GAC_ST_IDLE;
      tgt_q <= GAC_IDX_POS_AMP_1;
    end else begin
      state_q <= state_d;
      tgt_q <= tgt_d;
    end
  end

  // Setting outputs straight from the stored words
  assign pos_amplitude_sel_1_o = wr.word[GAC_IDX_POS_AMP_1][GAC_POS_AMP_LSB +: GAC_POS_AMP_W];
  assign neg_fine_sel_0_o = wr.word[GAC_IDX_NEG_FINE_1_0][GAC_FINE_LO_LSB +: GAC_FINE_W];
  assign neg_fine_sel_1_o = wr.word[GAC_IDX_NEG_FINE_1_0][GAC_FINE_HI_LSB +: GAC_FINE_W];
  assign neg_fine_sel_2_o = wr.word[GAC_IDX_NEG_FINE_3_2][GAC_FINE_LO_LSB +: GAC_FINE_W];
  assign neg_fine_sel_3_o = wr.word[GAC_IDX_NEG_FINE_3_2][GAC_FINE_HI_LSB +: GAC_FINE_W];
  assign param_pending_o = (state_q == GAC_ST_PARAM);

  // Checks on capture, decode and storage
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_pin_write(logic dcx);
    $rose(write_strobe_n_i) && read_strobe_n_i && $past(rst_n_i) && (cmd_data_select_i == dcx);
  endsequence

  sequence s_cmd(gac_byte_t code);
    wr.evt && !wr.is_param && ext_cmd_en_i && (wr.wbyte == code) && !sw_reset_i;
  endsequence

  sequence s_param_for(gac_idx_t idx);
    (state_q == GAC_ST_PARAM) && (tgt_q == idx) && wr.evt && wr.is_param && !sw_reset_i;
  endsequence

  a_cmd_pin_capture: assert property ( // [RQ1]
    s_pin_write(1'b0) |=> wr.evt && !wr.is_param && (wr.wbyte == $past(data_i[GAC_BYTE_W-1:0])))
    else $error("command byte not captured on rising write strobe");

  a_read_blocks_capture: assert property ( // [RQ1]
    !read_strobe_n_i |=> !wr.evt)
    else $error("write captured while read strobe low");

  a_pos_amp_write: assert property ( // [RQ2]
    s_param_for(GAC_IDX_POS_AMP_1)
      |=> (pos_amplitude_sel_1_o == $past(wr.wbyte[3:0])) && !param_pending_o)
    else $error("positive amplitude not stored from parameter");

  a_neg_fine_1_0: assert property ( // [RQ3]
    s_param_for(GAC_IDX_NEG_FINE_1_0)
      |=> (neg_fine_sel_1_o == $past(wr.wbyte[6:4])) && (neg_fine_sel_0_o == $past(wr.wbyte[2:0])))
    else $error("negative fine settings one and zero not stored");

  a_neg_fine_3_2: assert property ( // [RQ4]
    s_param_for(GAC_IDX_NEG_FINE_3_2)
      |=> (neg_fine_sel_3_o == $past(wr.wbyte[6:4])) && (neg_fine_sel_2_o == $past(wr.wbyte[2:0])))
    else $error("negative fine settings three and two not stored");

  a_ext_enable_gate: assert property ( // [RQ5]
    wr.evt && !wr.is_param && !ext_cmd_en_i |=> !param_pending_o ##1 $stable(wr.word) || $past(sw_reset_i))
    else $error("gamma command acted on with extension enable low");

  a_cmd_to_pending: assert property ( // [RQ6]
    s_cmd(GAC_CMD_NEG_FINE_3_2) |=> param_pending_o && (tgt_q == GAC_IDX_NEG_FINE_3_2))
    else $error("accepted command did not await its parameter");

  a_stray_param_ignored: assert property ( // [RQ10]
    (state_q == GAC_ST_IDLE) && wr.evt && wr.is_param && !sw_reset_i |=> $stable(wr.word))
    else $error("parameter without command changed a setting");

  a_swrst_pos_amp: assert property ( // [RQ7]
    sw_reset_i |=> (pos_amplitude_sel_1_o == 4'h0) && !param_pending_o)
    else $error("software reset left positive amplitude nonzero");

  a_swrst_neg_1_0: assert property ( // [RQ8]
    sw_reset_i |=> (neg_fine_sel_1_o == 3'h0) && (neg_fine_sel_0_o == 3'h7))
    else $error("software reset default wrong for fine settings one and zero");

  a_swrst_neg_3_2: assert property ( // [RQ9]
    sw_reset_i |=> (neg_fine_sel_3_o == 3'h2) && (neg_fine_sel_2_o == 3'h2))
    else $error("software reset default wrong for fine settings three and two");

  a_hwrst_defaults: assert property (@(posedge clk_i) disable iff (1'b0) // [RQ11]
    !rst_n_i |-> (pos_amplitude_sel_1_o == 4'h0) && (neg_fine_sel_0_o == 3'h7) && (neg_fine_sel_1_o == 3'h0)
      && (neg_fine_sel_2_o == 3'h2) && (neg_fine_sel_3_o == 3'h2) && !param_pending_o)
    else $error("hardware reset defaults wrong");

  // Command and parameter bytes in general
  sequence s_any_cmd;
    wr.evt && !wr.is_param;
  endsequence

  sequence s_any_param;
    wr.evt && wr.is_param && !sw_reset_i;
  endsequence

  sequence s_refused_code;
    wr.evt && !wr.is_param && (wr.wbyte != GAC_CMD_POS_AMP_1) && (wr.wbyte != GAC_CMD_NEG_FINE_1_0)
      && (wr.wbyte != GAC_CMD_NEG_FINE_3_2);
  endsequence

  // Parameter byte taken on the pins
  a_param_pin_capture: assert property ( // [RQ10]
    s_pin_write(1'b1) |=> wr.evt && wr.is_param && (wr.wbyte == $past(data_i[GAC_BYTE_W-1:0])))
    else $error("parameter byte not captured on rising write strobe");

  // One event per strobe rise
  a_evt_single_cycle: assert property ( // [RQ1]
    wr.evt |=> !wr.evt)
    else $error("write event lasted more than one cycle");

  // Event only after a low then high strobe with read idle
  a_evt_needs_rise: assert property ( // [RQ1]
    wr.evt |-> $past(write_strobe_n_i) && !$past(write_strobe_n_i, 2) && $past(read_strobe_n_i))
    else $error("write event without a rising write strobe");

  // Captured byte moves only with an event
  a_wbyte_holds: assert property ( // [RQ1]
    !wr.evt |-> $stable(wr.wbyte) && $stable(wr.is_param))
    else $error("captured byte changed without an event");

  // Wait opened only by an enabled command
  a_pending_source: assert property ( // [RQ5]
    $rose(param_pending_o) |-> $past(wr.evt && !wr.is_param && ext_cmd_en_i && !sw_reset_i))
    else $error("parameter wait started without an enabled command");

  // Amplitude command awaits its parameter
  a_amp_cmd_pending: assert property ( // [RQ2]
    s_cmd(GAC_CMD_POS_AMP_1) |=> param_pending_o && (tgt_q == GAC_IDX_POS_AMP_1))
    else $error("amplitude command did not await its parameter");

  // First fine command awaits its parameter
  a_fine_cmd_pending: assert property ( // [RQ3]
    s_cmd(GAC_CMD_NEG_FINE_1_0) |=> param_pending_o && (tgt_q == GAC_IDX_NEG_FINE_1_0))
    else $error("fine command did not await its parameter");

  // Other codes close any wait
  a_other_code_refused: assert property ( // [RQ1]
    s_refused_code |=> !param_pending_o)
    else $error("unknown command left a parameter wait open");

  // Disabled command leaves the target slot alone
  a_disabled_cmd_tgt: assert property ( // [RQ5]
    s_any_cmd ##0 !ext_cmd_en_i |=> $stable(tgt_q))
    else $error("disabled command changed the target slot");

  // A parameter closes the wait
  a_param_ends_wait: assert property ( // [RQ10]
    param_pending_o ##0 s_any_param |=> !param_pending_o)
    else $error("parameter wait still open after a parameter");

  // Wait holds until a byte or software reset
  a_wait_holds: assert property ( // [RQ6]
    param_pending_o && !wr.evt && !sw_reset_i |=> param_pending_o && $stable(tgt_q))
    else $error("parameter wait dropped without a byte");

  // Target slot moves only on a command byte
  a_tgt_cmd_only: assert property ( // [RQ2]
    !(wr.evt && !wr.is_param) |=> $stable(tgt_q))
    else $error("target slot changed without a command");

  // A command byte never changes a setting
  a_cmd_keeps_settings: assert property ( // [RQ10]
    s_any_cmd |=> $stable(wr.word) || $past(sw_reset_i))
    else $error("command byte changed a setting");

  // Settings move only by a write or software reset
  a_settings_hold: assert property ( // [RQ2]
    !wr.we && !sw_reset_i |=> $stable(wr.word))
    else $error("setting changed with no write");

  // Amplitude write leaves the fine settings alone
  a_pos_amp_alone: assert property ( // [RQ2]
    s_param_for(GAC_IDX_POS_AMP_1)
      |=> $stable({neg_fine_sel_3_o, neg_fine_sel_2_o, neg_fine_sel_1_o, neg_fine_sel_0_o}))
    else $error("amplitude write disturbed a fine setting");

  // Fine one and zero write leaves the rest alone
  a_first_fine_alone: assert property ( // [RQ3]
    s_param_for(GAC_IDX_NEG_FINE_1_0) |=> $stable(pos_amplitude_sel_1_o) && $stable({neg_fine_sel_3_o, neg_fine_sel_2_o}))
    else $error("fine one and zero write disturbed another setting");

  // Fine three and two write leaves the rest alone
  a_second_fine_alone: assert property ( // [RQ4]
    s_param_for(GAC_IDX_NEG_FINE_3_2) |=> $stable(pos_amplitude_sel_1_o) && $stable({neg_fine_sel_1_o, neg_fine_sel_0_o}))
    else $error("fine three and two write disturbed another setting");

  // Ignored parameter bits stay clear in every word
  a_dropped_bits_zero: assert property ( // [RQ3]
    ((wr.word[GAC_IDX_POS_AMP_1] & ~GAC_MASK_POS_AMP) == 8'h00)
      && ((wr.word[GAC_IDX_NEG_FINE_1_0] & ~GAC_MASK_NEG_FINE) == 8'h00)
      && ((wr.word[GAC_IDX_NEG_FINE_3_2] & ~GAC_MASK_NEG_FINE) == 8'h00))
    else $error("ignored parameter bits were stored");

  // Software reset loads every whole word
  a_swrst_words: assert property ( // [RQ9]
    sw_reset_i |=> wr.word == {GAC_RST_NEG_FINE_3_2, GAC_RST_NEG_FINE_1_0, GAC_RST_POS_AMP_1})
    else $error("software reset left a stored word wrong");

  // No event or write while hardware reset is low
  a_hwrst_idle: assert property (@(posedge clk_i) disable iff (1'b0) // [RQ7]
    !rst_n_i |-> !wr.evt && !wr.we)
    else $error("hardware reset left a write event active");

endmodule

// ---- hw/gac_pkg.sv ----
package gac_pkg;

  // Interface bus width and byte width
  localparam int GAC_DATA_W = 18;
  localparam int GAC_BYTE_W = 8;

  typedef logic [GAC_BYTE_W-1:0] gac_byte_t;

  // Command codes of the three gamma setting commands
  localparam gac_byte_t GAC_CMD_POS_AMP_1 = 8'hF5;
  localparam gac_byte_t GAC_CMD_NEG_FINE_1_0 = 8'hF7;
  localparam gac_byte_t GAC_CMD_NEG_FINE_3_2 = 8'hF8;

  // Register slots, one per command
  localparam int GAC_NUM_REGS = 3;
  typedef logic [1:0] gac_idx_t;
  localparam gac_idx_t GAC_IDX_POS_AMP_1 = 2'h0;
  localparam gac_idx_t GAC_IDX_NEG_FINE_1_0 = 2'h1;
  localparam gac_idx_t GAC_IDX_NEG_FINE_3_2 = 2'h2;

  // Field positions and widths
  localparam int GAC_POS_AMP_LSB = 0;
  localparam int GAC_POS_AMP_W = 4;
  localparam int GAC_FINE_LO_LSB = 0;
  localparam int GAC_FINE_HI_LSB = 4;
  localparam int GAC_FINE_W = 3;

  // Reset values, same after power-on, hardware and software reset
  localparam gac_byte_t GAC_RST_POS_AMP_1 = 8'h00;
  localparam gac_byte_t GAC_RST_NEG_FINE_1_0 = 8'h07;
  localparam gac_byte_t GAC_RST_NEG_FINE_3_2 = 8'h22;
  localparam gac_byte_t GAC_RST_VAL [GAC_NUM_REGS] = '{GAC_RST_POS_AMP_1, GAC_RST_NEG_FINE_1_0,
                                                      GAC_RST_NEG_FINE_3_2};

  // Bits kept from each parameter byte
  localparam gac_byte_t GAC_MASK_POS_AMP = 8'h0F;
  localparam gac_byte_t GAC_MASK_NEG_FINE = 8'h77;
  localparam gac_byte_t GAC_WR_MASK [GAC_NUM_REGS] = '{GAC_MASK_POS_AMP, GAC_MASK_NEG_FINE, GAC_MASK_NEG_FINE};

  // Command decoder states
  typedef enum logic [1:0] {
    GAC_ST_IDLE = 2'b01,
    GAC_ST_PARAM = 2'b10
  } gac_state_e;

endpackage

// ---- hw/gac_reg_store.sv ----
`timescale 1ns/1ps
module gac_reg_store (
  input wire logic clk_i,
  input wire logic rst_n_i,
  gac_wr_if.store_mp st
);
  import gac_pkg::*;

  // One register per command, reset to its own default
  for (genvar i = 0; i < GAC_NUM_REGS; i++) begin : g_reg
    gac_byte_t word_q, word_d;

    // Software reset wins over a write in the same cycle
    always_comb begin
      word_d = word_q;
      if (st.swrst) begin
        word_d = GAC_RST_VAL[i]; // [RQ7] [RQ8] [RQ9]
      end else if (st.we && (st.widx == gac_idx_t'(i))) begin
        word_d = st.wdata & GAC_WR_MASK[i]; // [RQ2] [RQ3] [RQ4]
      end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        word_q <= GAC_RST_VAL[i]; // [RQ7] [RQ8] [RQ11]
      end else begin
        word_q <= word_d;
      end
    end

    assign st.word[i] = word_q;
  end
endmodule

// ---- hw/gac_wr_edge.sv ----
`timescale 1ns/1ps
module gac_wr_edge #(
  parameter int DATA_W = gac_pkg::GAC_DATA_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic write_strobe_n_i,
  input wire logic read_strobe_n_i,
  input wire logic cmd_data_select_i,
  input wire logic [DATA_W-1:0] data_i,
  gac_wr_if.edge_mp wr
);
  import gac_pkg::*;

  // Bus must at least carry one byte
  if (DATA_W < GAC_BYTE_W) begin : g_bad_width
    $error("DATA_W must be at least one byte");
  end

  logic strobe_q, strobe_d;
  logic evt_q, evt_d;
  logic is_param_q, is_param_d;
  gac_byte_t byte_q, byte_d;

  // Rising write strobe with read strobe idle captures the low byte
  always_comb begin
    strobe_d = write_strobe_n_i;
    evt_d = write_strobe_n_i & ~strobe_q & read_strobe_n_i; // [RQ1]
    is_param_d = is_param_q;
    byte_d = byte_q;
    if (evt_d) begin
      is_param_d = cmd_data_select_i;
      byte_d = data_i[GAC_BYTE_W-1:0]; // upper lines ignored
    end
  end

  // Idle strobe level is high
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strobe_q <= 1'b1;
      evt_q <= 1'b0;
      is_param_q <= 1'b0;
      byte_q <= 8'h00;
    end else begin
      strobe_q <= strobe_d;
      evt_q <= evt_d;
      is_param_q <= is_param_d;
      byte_q <= byte_d;
    end
  end

  assign wr.evt = evt_q;
  assign wr.is_param = is_param_q;
  assign wr.wbyte = byte_q;
endmodule

// ---- hw/gac_wr_if.sv ----
`timescale 1ns/1ps
interface gac_wr_if;
  import gac_pkg::*;

  // Captured write events from the pins
  logic evt;
  logic is_param;
  gac_byte_t wbyte;
  // Register write port
  logic we;
  logic swrst;
  gac_idx_t widx;
  gac_byte_t wdata;
  // Stored register words
  logic [GAC_NUM_REGS-1:0][GAC_BYTE_W-1:0] word;

  modport edge_mp (output evt, output is_param, output wbyte);
  modport core_mp (input evt, input is_param, input wbyte, input word,
                   output we, output swrst, output widx, output wdata);
  modport store_mp (input we, input swrst, input widx, input wdata, output word);
endinterface
